// [logic/rdos_sched.sv]
/*
 * target-side request scheduler: holds fetched requests, runs them,
 * announces reverse data by unsolicited status and routes it to a
 * matching receive request of the same channel.
 * assumes an apb master, a fetch engine, a data mover and a status writer
 * outside, all on clk_i.
 */
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module rdos_sched
    import rdos_pkg::*;
#(
    parameter logic [31:0] TMO_CYC = REV_TMO_CYC  // reverse timeout reset value
) (
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    // apb slave
    input  wire logic            psel_i,
    input  wire logic            penable_i,
    input  wire logic            pwrite_i,
    input  wire logic [7:0]      paddr_i,
    input  wire logic [31:0]     pwdata_i,
    output logic      [31:0]     prdata_o,
    output logic                 pready_o,
    output logic                 pslverr_o,
    // fetched requests
    input  wire logic            orb_valid_i,
    input  wire rdos_orb_s       orb_i,
    output logic                 orb_ready_o,
    input  wire logic            doorbell_i,
    input  wire logic            login_i,
    output logic                 fetch_active_o,
    // reverse data offered by the function
    input  wire logic            rev_valid_i,
    input  wire logic [CHW-1:0]  rev_chan_i,
    input  wire logic [LENW-1:0] rev_len_i,
    output logic                 rev_ready_o,
    // data mover
    output logic                 xfer_valid_o,
    output rdos_xfer_s           xfer_o,
    input  wire logic            xfer_done_i,
    // status block writer
    output logic                 stat_valid_o,
    output rdos_stat_s           stat_o,
    input  wire logic            stat_ack_i
);
    logic        rst_q1;           // reset release stage one
    logic        rst_n;            // synchronised reset
    rdos_orb_s   slot [NSLOT];     // request slots in list order
    rdos_orb_s   next_slot [NSLOT];
    logic [CNTW-1:0] cnt;          // occupied slots
    logic [CNTW-1:0] next_cnt;
    rdos_state_e state;            // engine state
    rdos_state_e next_state;
    rdos_orb_s   cur;              // request being executed
    rdos_orb_s   next_cur;
    logic        cur_rev;          // current run carries reverse data
    logic        next_cur_rev;
    rdos_xfer_s  xfer;             // mover command register
    rdos_xfer_s  next_xfer;
    rdos_stat_s  stat;             // status block register
    rdos_stat_s  next_stat;
    logic        fetch;            // fetch agent active
    logic        next_fetch;
    logic        usol_en;          // unsolicited status enable
    logic        next_usol_en;
    logic [31:0] tmo_cfg;          // reverse timeout in cycles
    logic [31:0] next_tmo_cfg;
    logic        tmo_flag;         // sticky timeout seen
    logic        next_tmo_flag;
    logic        pend;             // reverse data waiting
    logic        next_pend;
    logic [CHW-1:0]  pchan;        // channel of waiting data
    logic [CHW-1:0]  next_pchan;
    logic [LENW-1:0] plen;         // bytes still waiting
    logic [LENW-1:0] next_plen;
    logic        due;              // announcement owed
    logic        next_due;
    logic [31:0] tcnt;             // timeout down counter
    logic [31:0] next_tcnt;
    logic [31:0] prdata;           // read data register
    logic [31:0] next_prdata;
    logic [IDXW:0] hit_new;        // receive match for offered data
    logic [IDXW:0] hit_pend;       // receive match for waiting data

    // oldest receive request of a channel; msb flags found
    function automatic logic [IDXW:0] find_rx(input rdos_orb_s s [NSLOT],
                                              input logic [CNTW-1:0] n,
                                              input logic [CHW-1:0] ch);
        logic [IDXW:0] r;
        r = '0;
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if ((CNTW'(i) < n) && (s[i].dir == DIR_WR) && (s[i].chan == ch)) begin
                r = {1'b1, IDXW'(i)};
            end
        end
        return r;
    endfunction

    // true for a mapped register offset
    function automatic logic reg_hit(input logic [7:0] a);
        return (a == ADR_CTRL) || (a == ADR_TMO) || (a == ADR_STAT);
    endfunction

    // reset release through two flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // matches searched in the slot list
    assign hit_new  = find_rx(slot, cnt, rev_chan_i);
    assign hit_pend = find_rx(slot, cnt, pchan);

    // handshake outputs
    assign pready_o       = 1'b1;
    assign pslverr_o      = psel_i && penable_i && !reg_hit(paddr_i);
    assign prdata_o       = prdata;
    assign orb_ready_o    = fetch && (cnt != CNTW'(NSLOT));
    assign fetch_active_o = fetch;
    assign rev_ready_o    = !pend;
    assign xfer_valid_o   = (state == ST_XFER);
    assign xfer_o         = xfer;
    assign stat_valid_o   = (state == ST_STAT) || (state == ST_USOL);
    assign stat_o         = stat;

    // next state of the scheduler and its registers
    always_comb begin
        logic [IDXW:0] pick;
        logic          take;
        logic          wr;
        pick          = '0;
        take          = 1'b0;
        wr            = psel_i && penable_i && pwrite_i;
        next_slot     = slot;
        next_cnt      = cnt;
        next_state    = state;
        next_cur      = cur;
        next_cur_rev  = cur_rev;
        next_xfer     = xfer;
        next_stat     = stat;
        next_fetch    = fetch;
        next_usol_en  = usol_en;
        next_tmo_cfg  = tmo_cfg;
        next_tmo_flag = tmo_flag;
        next_pend     = pend;
        next_pchan    = pchan;
        next_plen     = plen;
        next_due      = due;
        next_tcnt     = tcnt;
        next_prdata   = prdata;

        // offered reverse data: announce unless a big enough buffer waits
        if (rev_valid_i && !pend) begin
            next_pend  = 1'b1;
            next_pchan = rev_chan_i;
            next_plen  = rev_len_i;
            next_tcnt  = '0;
            next_due   = !hit_new[IDXW] ||
                         (slot[hit_new[IDXW-1:0]].size < rev_len_i);
        end

        // reverse timeout counts down after the announcement
        if (pend && !due && (tcnt != '0) && !(state == ST_XFER && cur_rev)) begin
            next_tcnt = tcnt - 32'h1;
            if (tcnt == 32'h1) begin
                next_pend     = 1'b0;
                next_tmo_flag = 1'b1;
            end
        end

        unique case (state)
            ST_IDLE: begin
                if (due && usol_en && pend) begin
                    // announce waiting data; transport status left zero
                    next_stat  = '{src: SRC_USOL, resp: RESP_OK,
                                   sbp: SBP_NONE, chan: pchan};
                    next_state = ST_USOL;
                end else if (pend && hit_pend[IDXW]) begin
                    // skip ahead to the channel's receive request
                    pick         = hit_pend;
                    take         = 1'b1;
                    next_cur_rev = 1'b1;
                    next_tcnt    = '0;
                end else if (cnt != '0) begin
                    // normal processing from the head of the list
                    pick         = '0;
                    take         = 1'b1;
                    next_cur_rev = 1'b0;
                end
            end
            ST_XFER: begin
                if (xfer_done_i) begin
                    if (cur_rev) begin
                        // bytes beyond the buffer stay waiting
                        if (plen > cur.size) begin
                            next_plen = plen - cur.size;
                            next_due  = 1'b1;
                        end else begin
                            next_pend = 1'b0;
                            next_due  = 1'b0;
                        end
                    end
                    if (cur.notify) begin
                        next_stat  = '{src: cur.next_ptr[31] ? SRC_NULL : SRC_MORE,
                                       resp: RESP_OK, sbp: SBP_NONE, chan: cur.chan};
                        next_state = ST_STAT;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_STAT: begin
                if (stat_ack_i) begin
                    next_state = ST_IDLE;
                end
            end
            ST_USOL: begin
                if (stat_ack_i) begin
                    next_usol_en = 1'b0;
                    next_due     = 1'b0;
                    next_tcnt    = tmo_cfg;
                    next_state   = ST_IDLE;
                end
            end
        endcase

        // move the chosen request out and close the gap
        if (take) begin
            next_cur   = slot[pick[IDXW-1:0]];
            next_state = ST_XFER;
            // direction 0 reads, 1 writes initiator memory as bus initiator
            next_xfer.dir  = slot[pick[IDXW-1:0]].dir;
            next_xfer.chan = slot[pick[IDXW-1:0]].chan;
            next_xfer.size = slot[pick[IDXW-1:0]].size;
            if (next_cur_rev && (plen < slot[pick[IDXW-1:0]].size)) begin
                next_xfer.size = plen;
            end
            for (int i = 0; i < NSLOT - 1; i++) begin
                if (IDXW'(i) >= pick[IDXW-1:0]) begin
                    next_slot[i] = slot[i + 1];
                end
            end
            next_cnt = cnt - CNTW'(1);
        end

        // append a fetched request; a null link suspends fetching
        if (orb_valid_i && orb_ready_o) begin
            next_slot[next_cnt[IDXW-1:0]] = orb_i;
            next_cnt = next_cnt + CNTW'(1);
            if (orb_i.next_ptr[31]) begin
                next_fetch = 1'b0;
            end
        end
        if (doorbell_i && !fetch) begin
            next_fetch = 1'b1;
        end

        // one login: a fresh login disables unsolicited status
        if (login_i) begin
            next_usol_en = 1'b0;
        end

        // register writes; software enable wins over hardware clear
        if (wr && (paddr_i == ADR_CTRL)) begin
            next_usol_en = pwdata_i[CTRL_USOL];
        end
        if (wr && (paddr_i == ADR_TMO)) begin
            next_tmo_cfg = pwdata_i;
        end
        if (wr && (paddr_i == ADR_STAT) && pwdata_i[STAT_TMO]) begin
            next_tmo_flag = 1'b0;
        end
        if (pend && !due && (tcnt == 32'h1) && !(state == ST_XFER && cur_rev)) begin
            next_tmo_flag = 1'b1;                                      // set wins over clear
        end

        // read data captured in the setup phase
        if (psel_i && !penable_i && !pwrite_i) begin
            next_prdata = WORD_RST;
            if (paddr_i == ADR_CTRL) begin
                next_prdata[CTRL_USOL] = usol_en;
            end else if (paddr_i == ADR_TMO) begin
                next_prdata = tmo_cfg;
            end else if (paddr_i == ADR_STAT) begin
                next_prdata[STAT_PEND]  = pend;
                next_prdata[STAT_DUE]   = due;
                next_prdata[STAT_TMO]   = tmo_flag;
                next_prdata[STAT_FETCH] = fetch;
                next_prdata[STAT_CHAN +: CHW] = pchan;
                next_prdata[STAT_CNT +: CNTW] = cnt;
            end
        end
    end

    // scheduler registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NSLOT; i++) begin
                slot[i] <= '0;
            end
            cnt      <= '0;
            state    <= ST_IDLE;
            cur      <= '0;
            cur_rev  <= 1'b0;
            xfer     <= '0;
            stat     <= '0;
            fetch    <= FETCH_RST;
            usol_en  <= USOL_RST;
            tmo_cfg  <= TMO_CYC;
            tmo_flag <= 1'b0;
            pend     <= 1'b0;
            pchan    <= '0;
            plen     <= '0;
            due      <= 1'b0;
            tcnt     <= '0;
            prdata   <= WORD_RST;
        end else begin
            slot     <= next_slot;
            cnt      <= next_cnt;
            state    <= next_state;
            cur      <= next_cur;
            cur_rev  <= next_cur_rev;
            xfer     <= next_xfer;
            stat     <= next_stat;
            fetch    <= next_fetch;
            usol_en  <= next_usol_en;
            tmo_cfg  <= next_tmo_cfg;
            tmo_flag <= next_tmo_flag;
            pend     <= next_pend;
            pchan    <= next_pchan;
            plen     <= next_plen;
            due      <= next_due;
            tcnt     <= next_tcnt;
            prdata   <= next_prdata;
        end
    end
endmodule : rdos_sched

// [logic/rdos_pkg.sv]
/*
 * constants, field layouts and carrier types of the reverse-data request scheduler.
 * assumes a single 25 MHz clock and a 32-bit apb register port.
 */
// Summary of operation
// - channel travels inside each request's command field
// - no receive buffer: send data-waiting unsolicited status
// - reply exceeds buffer: announce remaining data
// - finish outbound request, then search receive request
// - receive request must match pending data channel
// - after reverse data resume at skipped request
// - completion status only when notify bit set
// - no receive request: time out, keep outbound
// - spontaneous data announced and delivered likewise
// - per channel, each direction strictly in order
// - inbound request may run before earlier outbound
// - one channel may run ahead of another
// - at least one login accepted
// - peer nodes provide target and initiator roles
// - next pointer with top bit set is null
// - direction zero reads, one writes initiator memory
// - unsolicited status only while enabled, then cleared
// - unsolicited status uses source code two
package rdos_pkg;
    localparam int NSLOT = 4;    // request slots held on chip
    localparam int IDXW  = 2;    // slot index width
    localparam int CNTW  = 3;    // slot count width
    localparam int CHW   = 8;    // logical channel width
    localparam int LENW  = 16;   // byte length width
    // register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_TMO  = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;
    // field positions
    localparam int CTRL_USOL  = 0;
    localparam int STAT_PEND  = 0;
    localparam int STAT_DUE   = 1;
    localparam int STAT_TMO   = 2;
    localparam int STAT_FETCH = 3;
    localparam int STAT_CHAN  = 8;
    localparam int STAT_CNT   = 16;
    // status block and transfer direction codes
    localparam logic [1:0] SRC_MORE = 2'h0;
    localparam logic [1:0] SRC_NULL = 2'h1;
    localparam logic [1:0] SRC_USOL = 2'h2;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [7:0] SBP_NONE = 8'h00;
    localparam logic       DIR_RD   = 1'b0;
    localparam logic       DIR_WR   = 1'b1;
    // reverse timeout: time in ms, cycles derived from the clock rate
    localparam int CLK_KHZ     = 25000;
    localparam int REV_TMO_MS  = 100;
    localparam int REV_TMO_CYC = REV_TMO_MS * CLK_KHZ;
    // reset values
    localparam logic        USOL_RST = 1'b0;
    localparam logic        FETCH_RST = 1'b1;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    typedef struct packed {
        logic [31:0]     next_ptr;  // link to following request
        logic            dir;       // transfer direction
        logic            notify;    // status wanted on completion
        logic [CHW-1:0]  chan;      // channel from command field
        logic [LENW-1:0] size;      // buffer size in bytes
    } rdos_orb_s;

    typedef struct packed {
        logic            dir;       // 0 read, 1 write initiator memory
        logic [CHW-1:0]  chan;      // channel of the data
        logic [LENW-1:0] size;      // bytes to move
    } rdos_xfer_s;

    typedef struct packed {
        logic [1:0]     src;        // status source code
        logic [1:0]     resp;       // response code
        logic [7:0]     sbp;        // transport status
        logic [CHW-1:0] chan;       // channel concerned
    } rdos_stat_s;

    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_STAT, ST_USOL} rdos_state_e;
endpackage : rdos_pkg

// [dv/rdos_sched_asserts.sv]
/* port checker for the request scheduler, bound to rdos_sched.
   assumes the apb, request, reverse and status ports of that module. */
`timescale 1ns/1ps
module rdos_sched_asserts
    import rdos_pkg::*;
#(
    parameter logic [31:0] TMO_CYC = REV_TMO_CYC
) (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       psel_i,
    input wire logic       penable_i,
    input wire logic       pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic       orb_valid_i,
    input wire rdos_orb_s  orb_i,
    input wire logic       orb_ready_o,
    input wire logic       login_i,
    input wire logic       fetch_active_o,
    input wire logic       rev_valid_i,
    input wire logic       rev_ready_o,
    input wire logic       xfer_valid_o,
    input wire rdos_xfer_s xfer_o,
    input wire logic       xfer_done_i,
    input wire logic       stat_valid_o,
    input wire rdos_stat_s stat_o,
    input wire logic       stat_ack_i
);
    logic en;      // shadow of the unsolicited enable
    logic next_en; // its next value
    // a ctrl write wins over the hardware clears
    always_comb begin
        next_en = en;
        if (login_i || (stat_valid_o && stat_ack_i && stat_o.src == SRC_USOL)) begin
            next_en = 1'b0;
        end
        if (psel_i && penable_i && pwrite_i && paddr_i == ADR_CTRL) begin
            next_en = pwdata_i[CTRL_USOL];
        end
    end
    // shadow register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en <= USOL_RST;
        end else begin
            en <= next_en;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    rev_take_busy_a: assert property (rev_valid_i && rev_ready_o |=> !rev_ready_o)
        else $error("reverse data accepted but ready stayed high");
    xfer_hold_a: assert property (xfer_valid_o && !xfer_done_i |=>
        xfer_valid_o && $stable(xfer_o)) else $error("transfer dropped early");
    stat_hold_a: assert property (stat_valid_o && !stat_ack_i |=>
        stat_valid_o && $stable(stat_o)) else $error("status dropped early");
    usol_pend_a: assert property (stat_valid_o && stat_o.src == SRC_USOL |-> !rev_ready_o)
        else $error("unsolicited status without pending data");
    stat_after_a: assert property ($rose(stat_valid_o) && stat_o.src != SRC_USOL |->
        $past(xfer_valid_o) && $past(xfer_done_i)) else $error("status with no transfer done");
    usol_en_a: assert property ($rose(stat_valid_o) && stat_o.src == SRC_USOL |-> en)
        else $error("unsolicited status while disabled");
    null_stop_a: assert property (orb_valid_i && orb_ready_o && orb_i.next_ptr[31] |=>
        !orb_ready_o) else $error("request taken after null link");
    susp_cause_a: assert property ($fell(fetch_active_o) |-> $past(orb_valid_i) &&
        $past(orb_ready_o) && $past(orb_i.next_ptr[31]))
        else $error("fetch stopped without null link");
endmodule // rdos_sched_asserts

bind rdos_sched rdos_sched_asserts #(.TMO_CYC(TMO_CYC)) chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .orb_valid_i(orb_valid_i), .orb_i(orb_i), .orb_ready_o(orb_ready_o),
    .login_i(login_i), .fetch_active_o(fetch_active_o), .rev_valid_i(rev_valid_i),
    .rev_ready_o(rev_ready_o), .xfer_valid_o(xfer_valid_o), .xfer_o(xfer_o),
    .xfer_done_i(xfer_done_i), .stat_valid_o(stat_valid_o), .stat_o(stat_o),
    .stat_ack_i(stat_ack_i));

// [dv/rdos_init_model.sv]
/* far-side model: data mover and status sink of the initiator.
   assumes level valids held until the one-cycle done or ack pulse. */
`timescale 1ns/1ps
module rdos_init_model #(
    parameter int XDLY = 3, // slow mover
    parameter int SDLY = 0  // prompt status sink
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic xfer_valid_i,
    input  wire logic stat_valid_i,
    output logic      xfer_done_o,
    output logic      stat_ack_o
);
    int xc; // cycles a transfer has waited
    int sc; // cycles a status has waited
    // answer each request once after its delay
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xc <= 0;
            sc <= 0;
            xfer_done_o <= 1'b0;
            stat_ack_o <= 1'b0;
        end else begin
            xc <= (xfer_valid_i && !xfer_done_o) ? xc + 1 : 0;
            sc <= (stat_valid_i && !stat_ack_o) ? sc + 1 : 0;
            xfer_done_o <= xfer_valid_i && !xfer_done_o && xc >= XDLY;
            stat_ack_o <= stat_valid_i && !stat_ack_o && sc >= SDLY;
        end
    end
endmodule // rdos_init_model

// [dv/tb_reverse_data_orb_scheduler.sv]
/* testbench of the request scheduler: apb, request list and reverse data.
   assumes rdos_sched, the far-side model and a 25 MHz clock. */
`timescale 1ns/1ps
module tb_reverse_data_orb_scheduler;
    import rdos_pkg::*;
    logic clk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, err, orb_valid = 0, orb_ready, doorbell = 0, login = 0;
    logic fetch_active, rev_valid = 0, rev_ready, xfer_valid, xfer_done, stat_valid, stat_ack;
    logic [CHW-1:0] rev_chan = 0;
    logic [LENW-1:0] rev_len = 0;
    rdos_orb_s orb = '0;
    rdos_xfer_s xfer;
    rdos_stat_s stat;
    rdos_xfer_s xq[$]; // finished transfers
    rdos_stat_s sq[$]; // acknowledged status blocks
    int n_errors = 0, samples_checked = 0;
    always #20 clk_i = ~clk_i;
    rdos_sched #(.TMO_CYC(32'd20)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .orb_valid_i(orb_valid),
        .orb_i(orb), .orb_ready_o(orb_ready), .doorbell_i(doorbell), .login_i(login),
        .fetch_active_o(fetch_active), .rev_valid_i(rev_valid), .rev_chan_i(rev_chan),
        .rev_len_i(rev_len), .rev_ready_o(rev_ready), .xfer_valid_o(xfer_valid),
        .xfer_o(xfer), .xfer_done_i(xfer_done), .stat_valid_o(stat_valid), .stat_o(stat),
        .stat_ack_i(stat_ack));
    rdos_init_model part_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .xfer_valid_i(xfer_valid),
        .stat_valid_i(stat_valid), .xfer_done_o(xfer_done), .stat_ack_o(stat_ack));
    // record every completed transfer and status handshake
    always @(posedge clk_i) begin
        if (xfer_valid && xfer_done) xq.push_back(xfer);
        if (stat_valid && stat_ack) sq.push_back(stat);
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1;
        do @(posedge clk_i); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_x(input rdos_xfer_s e);
        while (xq.size() == 0) @(posedge clk_i);
        chk("xfer", 32'(e), 32'(xq.pop_front()));
    endtask
    task automatic chk_s(input rdos_stat_s e);
        while (sq.size() == 0) @(posedge clk_i);
        chk("stat", 32'(e), 32'(sq.pop_front()));
    endtask
    task automatic push(input rdos_orb_s o);
        @(posedge clk_i);
        orb_valid <= 1; orb <= o;
        do @(posedge clk_i); while (orb_ready !== 1'b1);
        orb_valid <= 0;
    endtask
    task automatic offer(input logic [7:0] c, input logic [15:0] l);
        @(posedge clk_i);
        rev_valid <= 1; rev_chan <= c; rev_len <= l;
        do @(posedge clk_i); while (rev_ready !== 1'b1);
        rev_valid <= 0;
    endtask
    task automatic pulse(input bit db); // db high: doorbell, else login
        @(posedge clk_i);
        if (db) doorbell <= 1;
        else login <= 1;
        @(posedge clk_i);
        doorbell <= 0;
        login <= 0;
    endtask
    task automatic give_verdict;
        if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // cut a hang short
    initial begin
        repeat (6000) @(posedge clk_i);
        n_errors++;
        give_verdict;
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1;
        repeat (3) @(posedge clk_i);
        apb(0, ADR_CTRL, 0); chk("ctrl", 0, r);
        apb(0, ADR_TMO, 0); chk("tmo", 20, r);
        apb(0, ADR_STAT, 0); chk("status", 32'h8, r & 32'h7000f);
        apb(1, 8'h0c, 1); apb(0, 8'h0c, 0); chk("unmapped", 32'h1, {r[30:0], err});
        push('{32'h100, DIR_RD, 1'b1, 8'h01, 16'h8});
        chk_x('{DIR_RD, 8'h01, 16'h8});
        chk_s('{SRC_MORE, RESP_OK, SBP_NONE, 8'h01});
        apb(1, ADR_CTRL, 1); pulse(1'b0); apb(0, ADR_CTRL, 0); chk("ctrl", 0, r);
        apb(1, ADR_CTRL, 1); offer(8'h02, 16'h8);
        chk_s('{SRC_USOL, RESP_OK, SBP_NONE, 8'h02});
        apb(0, ADR_CTRL, 0); chk("ctrl", 0, r);
        push('{32'h100, DIR_WR, 1'b0, 8'h02, 16'h8});
        chk_x('{DIR_WR, 8'h02, 16'h8});
        apb(1, ADR_CTRL, 1); offer(8'h04, 16'hc);
        chk_s('{SRC_USOL, RESP_OK, SBP_NONE, 8'h04});
        push('{32'h100, DIR_WR, 1'b0, 8'h04, 16'h8});
        chk_x('{DIR_WR, 8'h04, 16'h8});
        apb(0, ADR_STAT, 0); chk("status", 32'h40b, r & 32'h7ff0f);
        apb(1, ADR_CTRL, 1);
        chk_s('{SRC_USOL, RESP_OK, SBP_NONE, 8'h04});
        push('{32'h100, DIR_WR, 1'b0, 8'h04, 16'h8});
        chk_x('{DIR_WR, 8'h04, 16'h4});
        apb(1, ADR_CTRL, 1); offer(8'h07, 16'h4);
        chk_s('{SRC_USOL, RESP_OK, SBP_NONE, 8'h07});
        push('{32'h100, DIR_RD, 1'b0, 8'h07, 16'h10});
        push('{32'h100, DIR_RD, 1'b0, 8'h09, 16'h10});
        push('{32'h100, DIR_WR, 1'b0, 8'h07, 16'h8});
        chk_x('{DIR_RD, 8'h07, 16'h10});
        chk_x('{DIR_WR, 8'h07, 16'h4});
        chk_x('{DIR_RD, 8'h09, 16'h10});
        apb(1, ADR_CTRL, 1); push('{32'h100, DIR_RD, 1'b0, 8'h07, 16'h10});
        push('{32'h100, DIR_WR, 1'b0, 8'h07, 16'h8}); offer(8'h07, 16'h4);
        chk_x('{DIR_RD, 8'h07, 16'h10});
        chk_x('{DIR_WR, 8'h07, 16'h4});
        apb(1, ADR_CTRL, 1); offer(8'h05, 16'h4);
        chk_s('{SRC_USOL, RESP_OK, SBP_NONE, 8'h05});
        repeat (40) @(posedge clk_i);
        apb(0, ADR_STAT, 0); chk("status", 32'hc, r & 32'h7000f);
        chk("rev_ready", 1, 32'(rev_ready));
        apb(1, ADR_STAT, 4); apb(0, ADR_STAT, 0); chk("status", 32'h8, r & 32'h7000f);
        push('{32'h8000_0000, DIR_RD, 1'b1, 8'h06, 16'h4});
        chk_x('{DIR_RD, 8'h06, 16'h4});
        chk_s('{SRC_NULL, RESP_OK, SBP_NONE, 8'h06});
        chk("fetch", 0, 32'(fetch_active));
        pulse(1'b1); @(posedge clk_i); chk("fetch", 1, 32'(fetch_active));
        chk("left", 0, 32'(xq.size() + sq.size()));
        give_verdict;
    end
endmodule // tb_reverse_data_orb_scheduler
